// [timer_consts.vh]
// Functional notes
// R1: Overflow flag, control bit 7, sets on 16-bit overflow, stays until software clears.
// R2: Overflow flag never sets while receive or transmit clock select is 1.
// R3: Event flag, bit 6, sets when trigger falling edge captures or reloads with enable.
// R4: Event flag raises timer interrupt request when enabled; stays until cleared.
// R5: No event-flag interrupt while up/down enabled or in dual-slope count mode.
// R6: Receive clock select bit 5 picks this timer's overflows for serial modes 1, 3.
// R7: Transmit clock select bit 4 picks this timer's overflows for serial modes 1, 3.
// R8: Trigger enable bit 3 allows trigger edges only when not clocking serial port.
// R9: Run control bit 2 starts timer when 1, stops when 0.
// R10: Source select bit 1: 0 counts clocks, 1 counts event pin falling edges.
// R11: Capture select 1 with trigger enable: trigger edge copies counter to capture register.
// R12: Capture select 0: reload on overflow, and on trigger edges when enabled.
// R13: Any serial clock select forces auto-reload on overflow, ignoring capture select.
// R14: Counter high byte at 0CDH, low byte at 0CCH.
// R15: Capture/reload high byte at 0CBH, low byte at 0CAH.
// R16: Control register at 0C8H, resets to zero, bit addressable.
// R17: Mode register at 0C9H, byte access, resets zero, fields as laid out below.
// R18: Three or four channel phase modes cycle forward, or reverse when direction set.
// R19: Two-phase modes: direction 0 means A leads, 1 means B leads.
// R20: Capture, auto-reload up/down and baud generator modes chosen by control bits; the counter here only counts up.
// R21: Event pin sampled every clock; high then low sample increments counter.
// R22: Phase mode groups channels 2, 3 or 4; codes 000 to 100, others reserved.
// R23: Software writes phase mode only while run control is 0.
// R24: Flags clear by writing 0 via byte write or single-bit write.
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
`define ADDR_CONTROL   8'hc8
`define ADDR_MODE      8'hc9
`define ADDR_RCAP_LOW  8'hca
`define ADDR_RCAP_HIGH 8'hcb
`define ADDR_CNT_LOW   8'hcc
`define ADDR_CNT_HIGH  8'hcd
`define CTL_RESET      8'h00
`define MODE_RESET     8'h00
`define BIT_OVF        3'h7
`define BIT_EXF        3'h6
`define BIT_RCLK       3'h5
`define BIT_TX_CLOCK_SELECT       3'h4
`define BIT_EXEN       3'h3
`define BIT_RUN        3'h2
`define BIT_SRC        3'h1
`define BIT_CPRL       3'h0
`define MODE_PHASE_DIRECTION      7
`define MODE_PHS_HI    6
`define MODE_PHS_LO    4
`define MODE_CM_HI     3
`define MODE_CM_LO     2
`define MODE_TOE       1
`define MODE_UP_DOWN_ENABLE      0
`define CM_STANDARD    2'h0
`define PHS_OFF        3'h0
`define PHS_AB         3'h1
`define PHS_ABC        3'h2
`define PHS_ABCD       3'h3
`define PHS_DUAL       3'h4
`define CNT_MAX        16'hffff
`endif

// [fall_detect.v]
`timescale 1ns/100ps
// ***********************************
// Pin synchroniser and falling edge
// ***********************************
module fall_detect (
   input  wire SYS_CLK,
   input  wire RST,
   input  wire PIN,
   output wire FALL
);
   reg sync1_reg;
   reg sync2_reg;
   reg last_reg;

   always @(posedge SYS_CLK) begin
      if (RST) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         last_reg  <= 1'b1;
      end else begin
         sync1_reg <= PIN;
         sync2_reg <= sync1_reg;
         last_reg  <= sync2_reg;
      end
   end

   // High sample then low sample
   assign FALL = last_reg & ~sync2_reg; // R21
endmodule // fall_detect

// [phase_sequencer.v]
`timescale 1ns/100ps
`include "timer_consts.vh"
// ***********************************
// Compare channel phase rotation
// ***********************************
module phase_sequencer (
   input  wire       SYS_CLK,
   input  wire       RST,
   input  wire       STEP,
   input  wire [2:0] MODE,
   input  wire       DIR,
   output reg  [3:0] ENABLES
);
   reg [1:0] idx_reg;
   reg [1:0] last;

   always @* begin
      case (MODE)
         `PHS_ABC: last = 2'h2;
         `PHS_ABCD: last = 2'h3;
         default: last = 2'h1;
      endcase
   end

   always @(posedge SYS_CLK) begin
      if (RST) begin
         idx_reg <= 2'h0;
      end else if (STEP) begin
         if (DIR == 1'b0) begin // R18
            idx_reg <= (idx_reg >= last) ? 2'h0 : idx_reg + 2'h1;
         end else begin
            idx_reg <= (idx_reg == 2'h0 || idx_reg > last) ? last : idx_reg - 2'h1;
         end
      end
   end

   // Two-phase: first slot is the leading channel per direction
   always @* begin
      case (MODE) // R22
         `PHS_OFF: ENABLES = 4'hf;
         `PHS_AB: ENABLES = (idx_reg[0] ^ DIR) ? 4'h2 : 4'h1; // R19
         `PHS_DUAL: ENABLES = (idx_reg[0] ^ DIR) ? 4'ha : 4'h5; // R19
         `PHS_ABC,
         `PHS_ABCD: ENABLES = 4'h1 << idx_reg; // R18
         default: ENABLES = 4'hf;
      endcase
   end
endmodule // phase_sequencer

// [timer_control_regs.v]
`timescale 1ns/100ps
`include "timer_consts.vh"
// ***********************************
// Timer registers and counter core
// ***********************************
module timer_control_regs (
   input  wire       SYS_CLK,
   input  wire       RST,
   input  wire [7:0] SFR_ADDR,
   input  wire [7:0] SFR_WDATA,
   input  wire       SFR_WR,
   input  wire       SFR_BIT_WR,
   input  wire [2:0] SFR_BIT_SEL,
   input  wire       SFR_BIT_VAL,
   output reg  [7:0] SFR_RDATA,
   input  wire       TIMER_INT_ENABLE,
   input  wire       PRESCALE_TICK,
   input  wire       EXT_TRIGGER_PIN,
   input  wire       EVENT_INPUT_PIN,
   output wire       TIMER_IRQ,
   output wire       OVERFLOW_PULSE,
   output wire       RX_USE_THIS_TIMER,
   output wire       TX_USE_THIS_TIMER,
   output wire       PHASE_STEP,
   output wire [3:0] CHANNEL_ENABLES,
   output wire [1:0] COUNT_MODE,
   output wire       TOGGLE_OUTPUT_ENABLE
);
   reg  [7:0]  control_reg;
   reg  [7:0]  mode_reg;
   reg  [15:0] counter_reg;
   reg  [15:0] rcap_reg;
   reg  [7:0]  control_next;
   reg  [15:0] counter_next;
   reg  [15:0] rcap_next;
   reg         ovf_pulse_reg;
   wire        trig_fall;
   wire        event_fall;
   wire        baud_mode;
   wire        tick;
   wire        overflow;
   wire        trig_event;
   wire        wr_ctl;

   fall_detect trig_sync (
      .SYS_CLK (SYS_CLK),
      .RST     (RST),
      .PIN     (EXT_TRIGGER_PIN),
      .FALL    (trig_fall)
   );

   fall_detect event_sync (
      .SYS_CLK (SYS_CLK),
      .RST     (RST),
      .PIN     (EVENT_INPUT_PIN),
      .FALL    (event_fall)
   );

   phase_sequencer phases (
      .SYS_CLK (SYS_CLK),
      .RST     (RST),
      .STEP    (ovf_pulse_reg),
      .MODE    (mode_reg[`MODE_PHS_HI:`MODE_PHS_LO]),
      .DIR     (mode_reg[`MODE_PHASE_DIRECTION]),
      .ENABLES (CHANNEL_ENABLES)
   );

   // ***********************************
   // Count path
   // ***********************************
   assign baud_mode = control_reg[`BIT_RCLK] | control_reg[`BIT_TX_CLOCK_SELECT];
   assign tick = control_reg[`BIT_RUN] & // R9
                 (control_reg[`BIT_SRC] ? event_fall : PRESCALE_TICK); // R10 R21
   assign overflow = tick & (counter_reg == `CNT_MAX);
   assign trig_event = trig_fall & control_reg[`BIT_EXEN] & ~baud_mode; // R8
   assign wr_ctl = SFR_WR & (SFR_ADDR == `ADDR_CONTROL);

   always @* begin
      counter_next = counter_reg;
      rcap_next    = rcap_reg;
      control_next = control_reg;
      if (wr_ctl) begin
         control_next = SFR_WDATA; // R16 R24
      end else if (SFR_BIT_WR && SFR_ADDR == `ADDR_CONTROL) begin
         control_next[SFR_BIT_SEL] = SFR_BIT_VAL; // R16 R24
      end
      if (tick) begin
         if (overflow && (baud_mode || !control_reg[`BIT_CPRL])) begin
            counter_next = rcap_reg; // R12 R13 R20
         end else begin
            counter_next = counter_reg + 16'h0001;
         end
      end
      if (trig_event) begin
         if (control_reg[`BIT_CPRL]) begin
            rcap_next = counter_reg; // R11
         end else begin
            counter_next = rcap_reg; // R12
         end
         control_next[`BIT_EXF] = 1'b1; // R3
      end
      if (overflow && !baud_mode) begin
         control_next[`BIT_OVF] = 1'b1; // R1 R2
      end
      if (SFR_WR && SFR_ADDR == `ADDR_CNT_LOW) begin
         counter_next[7:0] = SFR_WDATA; // R14
      end else if (SFR_WR && SFR_ADDR == `ADDR_CNT_HIGH) begin
         counter_next[15:8] = SFR_WDATA; // R14
      end else if (SFR_WR && SFR_ADDR == `ADDR_RCAP_LOW) begin
         rcap_next[7:0] = SFR_WDATA; // R15
      end else if (SFR_WR && SFR_ADDR == `ADDR_RCAP_HIGH) begin
         rcap_next[15:8] = SFR_WDATA; // R15
      end
   end

   always @(posedge SYS_CLK) begin
      if (RST) begin
         control_reg   <= `CTL_RESET;
         mode_reg      <= `MODE_RESET;
         counter_reg   <= 16'h0000;
         rcap_reg      <= 16'h0000;
         ovf_pulse_reg <= 1'b0;
      end else begin
         control_reg   <= control_next;
         counter_reg   <= counter_next;
         rcap_reg      <= rcap_next;
         ovf_pulse_reg <= overflow;
         if (SFR_WR && SFR_ADDR == `ADDR_MODE) begin
            mode_reg <= SFR_WDATA; // R17 R23
         end
      end
   end

   // ***********************************
   // Read path
   // ***********************************
   always @* begin
      if (SFR_ADDR == `ADDR_CONTROL) begin
         SFR_RDATA = control_reg;
      end else if (SFR_ADDR == `ADDR_MODE) begin
         SFR_RDATA = mode_reg;
      end else if (SFR_ADDR == `ADDR_RCAP_LOW) begin
         SFR_RDATA = rcap_reg[7:0];
      end else if (SFR_ADDR == `ADDR_RCAP_HIGH) begin
         SFR_RDATA = rcap_reg[15:8];
      end else if (SFR_ADDR == `ADDR_CNT_LOW) begin
         SFR_RDATA = counter_reg[7:0];
      end else if (SFR_ADDR == `ADDR_CNT_HIGH) begin
         SFR_RDATA = counter_reg[15:8];
      end else begin
         SFR_RDATA = 8'h00;
      end
   end

   // ***********************************
   // Outputs
   // ***********************************
   // Event flag masked in up/down or dual-slope count modes
   assign TIMER_IRQ = TIMER_INT_ENABLE & (control_reg[`BIT_OVF] | // R4
                      (control_reg[`BIT_EXF] & ~mode_reg[`MODE_UP_DOWN_ENABLE] & // R5
                       (mode_reg[`MODE_CM_HI:`MODE_CM_LO] == `CM_STANDARD)));
   assign OVERFLOW_PULSE       = ovf_pulse_reg;
   assign RX_USE_THIS_TIMER    = control_reg[`BIT_RCLK]; // R6
   assign TX_USE_THIS_TIMER    = control_reg[`BIT_TX_CLOCK_SELECT]; // R7
   assign PHASE_STEP           = ovf_pulse_reg;
   assign COUNT_MODE           = mode_reg[`MODE_CM_HI:`MODE_CM_LO];
   assign TOGGLE_OUTPUT_ENABLE = mode_reg[`MODE_TOE];
endmodule // timer_control_regs

// [timer_checker.sv]
`timescale 1ns/100ps
// **************************
// Timer register checker
// **************************
module timer_checker (
   input wire       SYS_CLK,
   input wire       RST,
   input wire [7:0] SFR_ADDR,
   input wire       SFR_WR,
   input wire       SFR_BIT_WR,
   input wire [7:0] SFR_RDATA,
   input wire       TIMER_INT_ENABLE,
   input wire       TIMER_IRQ,
   input wire       OVERFLOW_PULSE,
   input wire       RX_USE_THIS_TIMER,
   input wire       TX_USE_THIS_TIMER,
   input wire       PHASE_STEP,
   input wire [3:0] CHANNEL_ENABLES,
   input wire [1:0] COUNT_MODE,
   input wire       TOGGLE_OUTPUT_ENABLE
);
   wire c8 = SFR_ADDR == 8'hc8;
   wire wr = SFR_WR | SFR_BIT_WR;
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (RST);
   a_rx_select: assert property (c8 |-> RX_USE_THIS_TIMER == SFR_RDATA[5])
      else $error("rx select mismatch");
   a_tx_select: assert property (c8 |-> TX_USE_THIS_TIMER == SFR_RDATA[4])
      else $error("tx select mismatch");
   a_ovf_holds: assert property (c8 && SFR_RDATA[7] && !wr ##1 c8 |-> SFR_RDATA[7])
      else $error("overflow flag lost");
   a_evt_holds: assert property (c8 && SFR_RDATA[6] && !wr ##1 c8 |-> SFR_RDATA[6])
      else $error("event flag lost");
   a_ovf_in_baud: assert property (c8 && !wr && (SFR_RDATA[5] | SFR_RDATA[4])
      && !SFR_RDATA[7] ##1 c8 |-> !SFR_RDATA[7]) else $error("overflow flag in baud");
   a_ovf_pulse: assert property (c8 && !wr && !SFR_RDATA[7] ##1 c8 && SFR_RDATA[7]
      |-> ##[0:1] OVERFLOW_PULSE) else $error("no overflow pulse");
   a_irq_gate: assert property (!TIMER_INT_ENABLE |-> !TIMER_IRQ)
      else $error("irq while disabled");
   a_irq_dual: assert property (COUNT_MODE != 2'h0 && c8 && !SFR_RDATA[7] |-> !TIMER_IRQ)
      else $error("event irq in dual slope");
   a_phase_step: assert property (PHASE_STEP == OVERFLOW_PULSE)
      else $error("phase step mismatch");
   a_mode_view: assert property (SFR_ADDR == 8'hc9
      |-> {COUNT_MODE, TOGGLE_OUTPUT_ENABLE} == SFR_RDATA[3:1]) else $error("mode outputs");
   a_reset_state: assert property (disable iff (1'b0) RST |=> CHANNEL_ENABLES == 4'hf
      && !TIMER_IRQ) else $error("reset state");
endmodule // timer_checker
bind timer_control_regs timer_checker u_chk (.*);

// [sfr_master.sv]
`timescale 1ns/100ps
// **************************
// CPU register bus model
// **************************
module sfr_master (
   input  wire        clk,
   input  wire  [7:0] rdata,
   output logic [7:0] addr = 8'h00,
   output logic [7:0] wdata = 8'h00,
   output logic       wr = 1'b0,
   output logic       bit_wr = 1'b0,
   output logic [2:0] bit_sel = 3'h0,
   output logic       bit_val = 1'b0
);
   task put(input logic [7:0] a, d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      wdata <= ~d;
      @(negedge clk);
   endtask
   task put_bit(input logic [2:0] b, input logic v);
      @(posedge clk);
      addr <= 8'hc8;
      bit_sel <= b;
      bit_val <= v;
      bit_wr <= 1'b1;
      @(posedge clk);
      bit_wr <= 1'b0;
      bit_val <= ~v;
      @(negedge clk);
   endtask
   task get(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
   endtask
endmodule // sfr_master

// [tb.sv]
`timescale 1ns/100ps
// **************************
// Timer register bench
// **************************
module tb;
   logic        clk = 0, rst = 1, int_en = 1, tick = 1, trig = 1, evt = 1;
   wire  [7:0]  addr, wdata, rdata;
   wire  [2:0]  bsel;
   wire         wr, bwr, bval, irq, ovf, rx, tx, step, toe;
   wire  [3:0]  chan;
   wire  [1:0]  cm;
   int          fails = 0, total_checks = 0;
   logic [23:0] rows [8] = '{24'hc98e8e, 24'hcaa5a5, 24'hcb5a5a, 24'hcc3c3c,
                            24'hcdc3c3, 24'hc83030, 24'hc7ff00, 24'hceff00};
   sfr_master u_cpu (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr),
      .bit_wr(bwr), .bit_sel(bsel), .bit_val(bval));
   timer_control_regs u_dut (.SYS_CLK(clk), .RST(rst), .SFR_ADDR(addr), .SFR_WDATA(wdata),
      .SFR_WR(wr), .SFR_BIT_WR(bwr), .SFR_BIT_SEL(bsel), .SFR_BIT_VAL(bval),
      .SFR_RDATA(rdata), .TIMER_INT_ENABLE(int_en), .PRESCALE_TICK(tick),
      .EXT_TRIGGER_PIN(trig), .EVENT_INPUT_PIN(evt), .TIMER_IRQ(irq), .OVERFLOW_PULSE(ovf),
      .RX_USE_THIS_TIMER(rx), .TX_USE_THIS_TIMER(tx), .PHASE_STEP(step),
      .CHANNEL_ENABLES(chan), .COUNT_MODE(cm), .TOGGLE_OUTPUT_ENABLE(toe));
   task chk(input string n, input logic [7:0] e, g);
      total_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task rc(input logic [7:0] a, e);
      logic [7:0] d;
      u_cpu.get(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   task fall(input logic t);
      @(posedge clk);
      if (t) trig <= 0; else evt <= 0;
      repeat (6) @(posedge clk);
      trig <= 1;
      evt <= 1;
      repeat (6) @(posedge clk);
   endtask
   task ovf_step;
      @(posedge clk);
      tick <= 1;
      @(posedge clk);
      tick <= 0;
      repeat (2) @(posedge clk);
   endtask
   task phase(input logic [7:0] m);
      u_cpu.put(8'hc8, 8'h00);
      u_cpu.put(8'hc9, m);
      u_cpu.put(8'hc8, 8'h04);
   endtask
   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   always #12.5 clk = ~clk;
   initial begin
      #100000;
      fails++;
      stop_test;
   end
   initial begin
      repeat (16) @(posedge clk);
      rst <= 0;
      for (int a = 8'hc8; a <= 8'hcd; a++) rc(a[7:0], 8'h00);
      chk("chan", 8'h0f, {4'h0, chan});
      foreach (rows[i]) begin
         u_cpu.put(rows[i][23:16], rows[i][15:8]);
         rc(rows[i][23:16], rows[i][7:0]);
      end
      chk("mode", 8'h07, {5'h0, cm, toe});
      chk("serial", 8'h03, {6'h0, rx, tx});
      u_cpu.put(8'hc9, 8'h00);
      u_cpu.put(8'hca, 8'hf0);
      u_cpu.put(8'hcb, 8'hff);
      u_cpu.put(8'hcc, 8'hfe);
      u_cpu.put(8'hcd, 8'hff);
      u_cpu.put(8'hc8, 8'h04);
      repeat (20) @(posedge clk);
      u_cpu.put_bit(3'h2, 1'b0);
      rc(8'hc8, 8'h80);
      rc(8'hcd, 8'hff);
      rc(8'hcc, 8'hf4);
      chk("irq", 8'h01, {7'h0, irq});
      u_cpu.put_bit(3'h7, 1'b0);
      rc(8'hc8, 8'h00);
      u_cpu.put(8'hcc, 8'hfe);
      u_cpu.put(8'hc8, 8'h35);
      repeat (40) @(posedge clk);
      u_cpu.put_bit(3'h2, 1'b0);
      rc(8'hc8, 8'h31);
      rc(8'hcd, 8'hff);
      u_cpu.put_bit(3'h3, 1'b1);
      u_cpu.put(8'hcb, 8'h00);
      fall(1);
      rc(8'hcb, 8'h00);
      rc(8'hc8, 8'h39);
      u_cpu.put(8'hc8, 8'h01);
      fall(1);
      rc(8'hcb, 8'h00);
      u_cpu.put(8'hcc, 8'h34);
      u_cpu.put(8'hcd, 8'h12);
      u_cpu.put(8'hc8, 8'h09);
      fall(1);
      rc(8'hca, 8'h34);
      rc(8'hcb, 8'h12);
      rc(8'hc8, 8'h49);
      chk("irq", 8'h01, {7'h0, irq});
      u_cpu.put(8'hc9, 8'h04);
      chk("irq", 8'h00, {7'h0, irq});
      rc(8'hc8, 8'h49);
      u_cpu.put(8'hc9, 8'h01);
      chk("irq", 8'h00, {7'h0, irq});
      u_cpu.put(8'hc9, 8'h00);
      u_cpu.put(8'hcc, 8'h78);
      u_cpu.put(8'hc8, 8'h08);
      fall(1);
      rc(8'hcc, 8'h34);
      rc(8'hc8, 8'h48);
      @(posedge clk);
      int_en <= 0;
      @(posedge clk);
      chk("irq", 8'h00, {7'h0, irq});
      int_en <= 1;
      u_cpu.put(8'hcc, 8'h00);
      u_cpu.put(8'hc8, 8'h06);
      repeat (3) fall(0);
      u_cpu.put_bit(3'h2, 1'b0);
      rc(8'hcc, 8'h03);
      // Reset after run control is cleared, then step phases one overflow at a time
      @(posedge clk);
      rst <= 1;
      tick <= 0;
      repeat (2) @(posedge clk);
      rst <= 0;
      for (int a = 8'hc8; a <= 8'hcd; a++) rc(a[7:0], 8'h00);
      chk("chan", 8'h0f, {4'h0, chan});
      u_cpu.put(8'hca, 8'hff);
      u_cpu.put(8'hcb, 8'hff);
      u_cpu.put(8'hcc, 8'hff);
      u_cpu.put(8'hcd, 8'hff);
      phase(8'h20);
      chk("chan", 8'h01, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h02, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h04, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h01, {4'h0, chan});
      phase(8'h90);
      chk("chan", 8'h02, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h01, {4'h0, chan});
      phase(8'hb0);
      chk("chan", 8'h02, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h01, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h08, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h04, {4'h0, chan});
      phase(8'h40);
      chk("chan", 8'h05, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h05, {4'h0, chan});
      ovf_step;
      chk("chan", 8'h0a, {4'h0, chan});
      phase(8'h50);
      chk("chan", 8'h0f, {4'h0, chan});
      stop_test;
   end
endmodule // tb
